// *** core/dpc_port_ctrl.sv ***
// Purpose: Mode, drive, sampling, result streaming and status for a 32-bit digital port
// Assumes: Register port on clk; pins, external sample clock and trigger detectors are asynchronous
// Notes: Output data and the port clock pin change together on the port clock falling edge
`timescale 1ns/1ps

module dpc_port_ctrl
	import dpc_pkg::*;
#(
	parameter logic [31:0] DECIM_DEFAULT = dpc_pkg::DECIM_RST
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic [dpc_pkg::PORT_W-1:0] seq_out,
	input wire logic res_valid,
	input wire logic [dpc_pkg::RES_CHAN_W-1:0] res_chan,
	input wire logic [dpc_pkg::RES_DATA_W-1:0] res_data,
	input wire logic [dpc_pkg::PORT_W-1:0] pin_in,
	output logic [dpc_pkg::PORT_W-1:0] pin_out,
	output logic [dpc_pkg::PORT_W-1:0] pin_oe,
	output logic port_clk_out,
	input wire logic ext_clk_in,
	input wire logic [dpc_pkg::NTRIG-1:0] trig_low_det,
	input wire logic [dpc_pkg::NTRIG-1:0] trig_high_det,
	input wire logic nv_std_in,
	output logic nv_std_wr,
	output logic nv_std_data
);
	import dpc_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int SYNC_W = PORT_W + 1 + 2 * NTRIG;
	logic [SYNC_W-1:0] sync_q;
	logic [PORT_W-1:0] pin_s;
	logic ext_clk_s;
	logic ext_clk_d;
	logic [NTRIG-1:0] trig_low_s;
	logic [NTRIG-1:0] trig_high_s;

	dpc_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({trig_high_det, trig_low_det, ext_clk_in, pin_in}),
		.q(sync_q)
	);
	assign pin_s = sync_q[PORT_W-1:0];
	assign ext_clk_s = sync_q[PORT_W];
	assign trig_low_s = sync_q[PORT_W+1 +: NTRIG];
	assign trig_high_s = sync_q[PORT_W+1+NTRIG +: NTRIG];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [1:0] mode;
	logic ext_clk_sel;
	logic iface_std;
	logic std_load_pend;
	logic [NBUS-1:0] drive;
	logic [PORT_W-1:0] sw_out;
	logic [PORT_W-1:0] in_val;
	logic [31:0] decim;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic live_ovf;

	wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
	wire wr_drive = reg_wr && (reg_addr == REG_DRIVE);
	wire wr_out = reg_wr && (reg_addr == REG_OUT);
	wire wr_irq_stat = reg_wr && (reg_addr == REG_IRQ_STAT);
	wire wr_irq_mask = reg_wr && (reg_addr == REG_IRQ_MASK);
	wire wr_decim = reg_wr && (reg_addr == REG_DECIM);

	// Persistent standard: loaded from storage after reset, every write stored back
	always_ff @(posedge clk) begin
		if (rst) begin
			mode <= MODE_RST;
			ext_clk_sel <= 1'b0;
			iface_std <= 1'b0;
			std_load_pend <= 1'b1;
			nv_std_wr <= 1'b0;
			nv_std_data <= 1'b0;
		end else begin
			std_load_pend <= 1'b0;
			nv_std_wr <= wr_ctrl;
			nv_std_data <= wr_ctrl ? reg_wdata[CTRL_STD_BIT] : nv_std_data;
			if (wr_ctrl) begin
				mode <= reg_wdata[CTRL_MODE_LSB +: 2];
				ext_clk_sel <= reg_wdata[CTRL_EXTCLK_BIT];
				iface_std <= reg_wdata[CTRL_STD_BIT];
			end else if (std_load_pend) begin
				iface_std <= nv_std_in;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			drive <= DRIVE_RST;
			sw_out <= OUT_RST;
			decim <= DECIM_DEFAULT;
			irq_mask <= IRQ_MASK_RST;
		end else begin
			if (wr_drive)
				drive <= reg_wdata[NBUS-1:0];
			if (wr_out)
				sw_out <= reg_wdata;
			if (wr_decim)
				decim <= reg_wdata;
			if (wr_irq_mask)
				irq_mask <= reg_wdata[IRQ_W-1:0];
		end
	end

	// ----------------------------------------
	// Port clock and output update
	// ----------------------------------------
	logic [2:0] div_cnt;
	logic [PORT_W-1:0] out_reg;
	wire upd_tick = (div_cnt == PCLK_HIGH - 3'h1);
	wire pclk_rise = (div_cnt == PCLK_LAST);

	always_ff @(posedge clk) begin
		if (rst) begin
			div_cnt <= 3'h0;
			port_clk_out <= 1'b1;
		end else begin
			div_cnt <= pclk_rise ? 3'h0 : div_cnt + 3'h1;
			port_clk_out <= pclk_rise || (div_cnt < PCLK_HIGH - 3'h1);
		end
	end

	// ----------------------------------------
	// Result stream
	// ----------------------------------------
	// One result is held; a second arriving before the port slot is dropped,
	// since the port carries at most one result per port clock period.
	logic res_pend;
	logic [RES_CHAN_W-1:0] pend_chan;
	logic [RES_DATA_W-1:0] pend_data;
	wire in_result = (mode == MODE_RESULT);
	wire res_send = in_result && upd_tick && res_pend;
	wire res_drop = in_result && res_valid && res_pend && !res_send;
	wire [PORT_W-1:0] res_word = res_pend ?
		{8'h00, pend_data, 3'h0, pend_chan, 1'b1} : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (rst || !in_result) begin
			res_pend <= 1'b0;
			pend_chan <= '0;
			pend_data <= '0;
		end else if (res_valid && !res_drop) begin
			res_pend <= 1'b1;
			pend_chan <= res_chan;
			pend_data <= res_data;
		end else if (res_send) begin
			res_pend <= 1'b0;
		end
	end

	// Live flag covers the rest of the port period in which a drop happened
	always_ff @(posedge clk) begin
		if (rst)
			live_ovf <= 1'b0;
		else if (res_drop)
			live_ovf <= 1'b1;
		else if (upd_tick || !in_result)
			live_ovf <= 1'b0;
	end

	logic [PORT_W-1:0] next_out;
	always_comb begin
		case (mode)
			MODE_MANUAL: next_out = sw_out;
			MODE_SEQ: next_out = seq_out;
			MODE_RESULT: next_out = res_word;
			default: next_out = sw_out;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			out_reg <= OUT_RST;
		else if (upd_tick)
			out_reg <= next_out;
	end

	// ----------------------------------------
	// Bus drive
	// ----------------------------------------
	// Value held in out_reg even while undriven, so enabling shows it at once
	genvar gb;
	generate
		for (gb = 0; gb < NBUS; gb++) begin : g_bus
			assign pin_oe[gb*BUS_W +: BUS_W] = {BUS_W{drive[gb]}};
			assign pin_out[gb*BUS_W +: BUS_W] = out_reg[gb*BUS_W +: BUS_W] & {BUS_W{drive[gb]}};
		end
	endgenerate

	// ----------------------------------------
	// Input sampling with decimation
	// ----------------------------------------
	wire ext_rise = ext_clk_s && !ext_clk_d;
	wire samp_tick = ext_clk_sel ? ext_rise : pclk_rise;
	logic [31:0] dec_cnt;
	// A count of zero acts as one, so the latch never stalls
	wire dec_hit = samp_tick && ((decim <= 32'h1) || (dec_cnt >= decim - 32'h1));

	always_ff @(posedge clk) begin
		if (rst) begin
			ext_clk_d <= 1'b0;
			dec_cnt <= 32'h0000_0000;
			in_val <= '0;
		end else begin
			ext_clk_d <= ext_clk_s;
			if (dec_hit) begin
				dec_cnt <= 32'h0000_0000;
				in_val <= pin_s;
			end else if (samp_tick) begin
				dec_cnt <= dec_cnt + 32'h1;
			end
		end
	end

	// ----------------------------------------
	// Interrupts and sticky flags
	// ----------------------------------------
	wire [IRQ_W-1:0] irq_evt = {dec_hit, res_drop};
	wire [IRQ_W-1:0] irq_clr = wr_irq_stat ? reg_wdata[IRQ_W-1:0] : '0;

	always_ff @(posedge clk) begin
		if (rst)
			irq_stat <= '0;
		else
			irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
	end
	assign irq = |(irq_stat & irq_mask);

	// ----------------------------------------
	// Read back
	// ----------------------------------------
	wire [31:0] ctrl_rd = {28'h0, iface_std, ext_clk_sel, mode};
	wire [31:0] stat_rd = {{(32 - 2 - 2 * NTRIG){1'b0}}, trig_high_s, trig_low_s,
		irq_stat[IRQ_OVF_BIT], live_ovf};
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			REG_CTRL: rd_mux = ctrl_rd;
			REG_DRIVE: rd_mux = {28'h0, drive};
			REG_OUT: rd_mux = sw_out;
			REG_IN: rd_mux = in_val;
			REG_STAT: rd_mux = stat_rd;
			REG_IRQ_STAT: rd_mux = {30'h0, irq_stat};
			REG_IRQ_MASK: rd_mux = {30'h0, irq_mask};
			REG_DECIM: rd_mux = decim;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_manual_out_value: assert property (upd_tick && mode == MODE_MANUAL |=> out_reg == $past(sw_out))
		else $error("manual output not taken from software value");
	a_seq_out_value: assert property (upd_tick && mode == MODE_SEQ |=> out_reg == $past(seq_out))
		else $error("sequencer output not taken");
	a_result_word_sent: assert property (res_send |=> out_reg[RES_VALID_BIT] &&
		out_reg[RES_CHAN_LSB +: RES_CHAN_W] == $past(pend_chan) &&
		out_reg[RES_DATA_LSB +: RES_DATA_W] == $past(pend_data))
		else $error("result word wrong");
	a_live_ovf_hold: assert property (res_drop |=> live_ovf)
		else $error("live overflow not raised");
	a_sticky_ovf_set: assert property (res_drop |=> irq_stat[IRQ_OVF_BIT] ##1
		(irq_stat[IRQ_OVF_BIT] || $past(irq_clr[IRQ_OVF_BIT])))
		else $error("sticky overflow lost");
	a_drop_cause: assert property (in_result && res_valid && res_pend && !upd_tick |=>
		live_ovf && irq_stat[IRQ_OVF_BIT])
		else $error("fast result not flagged");
	a_bus_undriven: assert property (!drive[0] |-> pin_oe[BUS_W-1:0] == '0 && pin_out[BUS_W-1:0] == '0)
		else $error("undriven bus shows output");
	a_update_on_fall: assert property (upd_tick |=> !port_clk_out ##[1:4] port_clk_out)
		else $error("output update not at port clock fall");
	a_input_latch: assert property (dec_hit |=> in_val == $past(pin_s))
		else $error("input not latched at decimation");
	a_ext_clk_only: assert property (ext_clk_sel && !ext_rise |-> !samp_tick)
		else $error("sample tick without external edge");
	a_trig_low_seen: assert property ($rose(trig_low_s[0]) |-> stat_rd[STAT_TRIG_LOW_LSB])
		else $error("trigger low not shown");
	a_reset_inputs: assert property ($past(rst) |-> drive == DRIVE_RST)
		else $error("bus driven after reset");

	c_result_send: cover property (res_send);
	c_overflow: cover property (res_drop);
	c_ext_sample: cover property (ext_clk_sel && dec_hit);
	c_irq: cover property ($rose(irq));
endmodule

// *** core/dpc_sync.sv ***
// Purpose: Two flip-flop synchroniser for a vector of unrelated levels
// Assumes: Each bit is an independent level; no word coherence
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module dpc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// *** inc/dpc_pkg.sv ***
// Purpose: Shared constants for the digital I/O port control block
// Assumes: 250 MHz system clock, 32-bit port split into four byte buses
// Notes: Register offsets are byte addresses, one aligned word each
package dpc_pkg;

	// ----------------------------------------
	// Clocking
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int PCLK_MHZ = 50;
	localparam int PCLK_DIV = CLK_MHZ / PCLK_MHZ;
	// Port clock is high for the first part of each period
	localparam logic [2:0] PCLK_HIGH = 3'h3;
	localparam logic [2:0] PCLK_LAST = 3'(PCLK_DIV - 1);

	// ----------------------------------------
	// Port shape
	// ----------------------------------------
	localparam int PORT_W = 32;
	localparam int BUS_W = 8;
	localparam int NBUS = PORT_W / BUS_W;
	localparam int NTRIG = 2;

	// ----------------------------------------
	// Modes
	// ----------------------------------------
	localparam logic [1:0] MODE_MANUAL = 2'h0;
	localparam logic [1:0] MODE_SEQ = 2'h1;
	localparam logic [1:0] MODE_RESULT = 2'h2;

	// ----------------------------------------
	// Result word layout
	// ----------------------------------------
	localparam int RES_VALID_BIT = 0;
	localparam int RES_CHAN_LSB = 1;
	localparam int RES_CHAN_W = 4;
	localparam int RES_DATA_LSB = 8;
	localparam int RES_DATA_W = 16;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DRIVE = 8'h04;
	localparam logic [7:0] REG_OUT = 8'h08;
	localparam logic [7:0] REG_IN = 8'h0C;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_STAT = 8'h14;
	localparam logic [7:0] REG_IRQ_MASK = 8'h18;
	localparam logic [7:0] REG_DECIM = 8'h1C;

	// CTRL fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_EXTCLK_BIT = 2;
	localparam int CTRL_STD_BIT = 3;

	// STAT fields
	localparam int STAT_LIVE_OVF_BIT = 0;
	localparam int STAT_STICKY_OVF_BIT = 1;
	localparam int STAT_TRIG_LOW_LSB = 2;
	localparam int STAT_TRIG_HIGH_LSB = 2 + NTRIG;

	// Interrupt status bits
	localparam int IRQ_W = 2;
	localparam int IRQ_OVF_BIT = 0;
	localparam int IRQ_SAMPLE_BIT = 1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] MODE_RST = MODE_MANUAL;
	localparam logic [3:0] DRIVE_RST = 4'h0;
	localparam logic [31:0] OUT_RST = 32'h0000_0000;
	localparam logic [31:0] DECIM_RST = 32'h0055_D4A8;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

endpackage

// *** verification/digital_io_port_control_tb.sv ***
// Purpose: Self-checking bench for the port control block
// Assumes: Decimation shortened to 8 through the top parameter
// Notes: Reads are checked by a monitor from a queue of expectations
`timescale 1ns/1ps
module digital_io_port_control_tb;
	import dpc_pkg::*;
	logic clk, rst, reg_wr, reg_rd, irq, res_valid, port_clk_out, ext_clk_in;
	logic nv_std_in, nv_std_wr, nv_std_data, run, rd_seen, nv_last;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, seq_out, pin_in, pin_out, pin_oe, drv_val, v, iv;
	logic [3:0] res_chan;
	logic [15:0] res_data;
	logic [1:0] tlo, thi;
	logic [4:0] pc;
	logic [31:0] exp_q[$];
	logic [31:0] seed = 32'hE079;
	int fail_count = 0, num_checks = 0, cyc = 0, nv_cnt = 0;

	dpc_port_ctrl #(.DECIM_DEFAULT(32'h0000_0008)) i_dpc_port_ctrl (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .seq_out(seq_out), .res_valid(res_valid),
		.res_chan(res_chan), .res_data(res_data), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .port_clk_out(port_clk_out), .ext_clk_in(ext_clk_in),
		.trig_low_det(tlo), .trig_high_det(thi), .nv_std_in(nv_std_in),
		.nv_std_wr(nv_std_wr), .nv_std_data(nv_std_data));
	dpc_far_model i_dpc_far_model (.pin_out(pin_out), .pin_oe(pin_oe), .drv_val(drv_val),
		.run(run), .pin_in(pin_in), .ext_clk_in(ext_clk_in));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'h1;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'h0;
		@(posedge clk);
	endtask
	// Waits for the port clock to fall, where outputs update
	task automatic wait_fall();
		logic prev;
		#1;
		prev = port_clk_out;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			#1;
			if (prev && !port_clk_out) break;
			prev = port_clk_out;
		end
		@(posedge clk);
	endtask

	// ----------------------------------------
	// Clock, monitor, timeout
	// ----------------------------------------
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	initial begin
		rd_seen = 1'h0;
		forever begin
			@(posedge clk);
			#1;
			if (rd_seen) check("rdata", reg_rdata, exp_q.pop_front());
			rd_seen = reg_rd;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (nv_std_wr) begin
			nv_cnt <= nv_cnt + 1;
			nv_last <= nv_std_data;
		end
		// Run should end near 550 cycles
		if (cyc == 4000) begin
			fail_count++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{rst, nv_std_in} = 2'h3;
		{reg_wr, reg_rd, res_valid, run} = 4'h0;
		{reg_addr, reg_wdata, seq_out, drv_val, res_chan, res_data, tlo, thi} = '0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		check("oe", pin_oe, 32'h0);
		rd(REG_CTRL, 32'h8);
		rd(REG_DRIVE, 32'h0);
		rd(REG_IRQ_MASK, 32'h0);
		rd(REG_DECIM, 32'h8);
		rd(8'h20, 32'h0);
		v = xs();
		tlo <= v[1:0];
		thi <= v[3:2];
		repeat (4) @(posedge clk);
		rd(REG_STAT, {26'h0, v[3:2], v[1:0], 2'h0});
		wr(REG_CTRL, 32'h0);
		@(posedge clk);
		check("nv", {nv_cnt[30:0], nv_last}, 32'h2);
		iv = xs();
		wr(REG_DRIVE, 32'h5);
		wr(REG_OUT, iv);
		wait_fall();
		check("pin", pin_out, iv & 32'h00FF00FF);
		check("oe", pin_oe, 32'h00FF00FF);
		wr(REG_DRIVE, 32'hF);
		wait_fall();
		check("pin", pin_out, iv);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			pc = {pc[3:0], port_clk_out};
		end
		check("pclk", {27'h0, pc}, 32'h0000_000E);
		seq_out <= xs();
		wr(REG_CTRL, {30'h0, MODE_SEQ});
		wait_fall();
		check("pin", pin_out, seq_out);
		wr(REG_CTRL, 32'h3);
		wait_fall();
		check("pin", pin_out, iv);
		wr(REG_CTRL, {30'h0, MODE_RESULT});
		for (int c = 0; c < 4; c++) begin
			v = xs();
			wait_fall();
			res_chan <= 4'h1 << c;
			res_data <= v[15:0];
			res_valid <= 1'h1;
			@(posedge clk);
			res_valid <= 1'h0;
			for (int i = 0; i < 12 && pin_out[0] !== 1'h1; i++) @(posedge clk);
			check("word", pin_out, {8'h00, v[15:0], 3'h0, 4'h1 << c, 1'h1});
		end
		res_valid <= 1'h1;
		repeat (2) @(posedge clk);
		rd(REG_STAT, {26'h0, thi, tlo, 2'h3});
		res_valid <= 1'h0;
		repeat (12) @(posedge clk);
		rd(REG_STAT, {26'h0, thi, tlo, 2'h2});
		wr(REG_IRQ_MASK, 32'h1);
		check("irq", {31'h0, irq}, 32'h1);
		wr(REG_IRQ_MASK, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		wr(REG_IRQ_MASK, 32'h1);
		wr(REG_IRQ_STAT, 32'h1);
		check("irq", {31'h0, irq}, 32'h0);
		wr(REG_DRIVE, 32'h0);
		wr(REG_CTRL, 32'h0);
		iv = xs();
		drv_val <= iv;
		repeat (60) @(posedge clk);
		rd(REG_IN, iv);
		rd(REG_IRQ_STAT, 32'h2);
		// External clock selected but still: input must not be latched
		wr(REG_CTRL, 32'h4);
		drv_val <= xs();
		repeat (100) @(posedge clk);
		rd(REG_IN, iv);
		run <= 1'h1;
		repeat (220) @(posedge clk);
		rd(REG_IN, drv_val);
		run <= 1'h0;
		repeat (3) @(posedge clk);
		print_verdict();
	end
endmodule

// *** verification/dpc_far_model.sv ***
// Purpose: Far-side equipment on the port connector
// Assumes: It drives only the bytes that the device leaves as inputs
// Notes: Its sample clock stands still while not running, so no stray edges
`timescale 1ns/1ps
module dpc_far_model (
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	input wire logic [31:0] drv_val,
	input wire logic run,
	output logic [31:0] pin_in,
	output logic ext_clk_in
);
	// ----------------------------------------
	// Pins and sample clock
	// ----------------------------------------
	assign pin_in = (pin_out & pin_oe) | (drv_val & ~pin_oe);
	initial begin
		ext_clk_in = 1'h0;
		forever begin
			#40;
			ext_clk_in = run ? ~ext_clk_in : 1'h0;
		end
	end
endmodule
